/* include/pioc_pkg.sv */
// Package with register map, bus widths and reset values of the parallel I/O line controller
// ----------------------------------------------------------------------------
// Function
// - Pull-up enable clears status, disable sets
// - Pull-up status resets to zero
// - Up to 32 lines, same bit everywhere
// - Owner enable sets, disable clears ownership
// - Unmultiplexed lines always owned, read one
// - Ownership reset value is per-line parameter
// - Select A clears, select B sets
// - Selection steers outputs only, inputs shared
// - Peripheral select resets to A
// - Select writes work regardless of owner
// - Peripheral-owned line driven by selected peripheral
// - Output enable sets, disable clears status
// - Set and clear output change drive data
// - Output writes work under peripheral ownership
// - Direct data write changes only masked-in bits
// - Write mask resets to zero
// - Multi-drive lines drive low only
// - Multi-drive status resets to zero
// - Register writes need no gated clock
// - Sampling and interrupt need gated clock
// - Pin level register holds last sample
// - Sample change sets flag, masked OR
// - Status read returns and clears pending
// - Absent lines ignore writes, read zero
// ----------------------------------------------------------------------------
`default_nettype none
package pioc_pkg;

  localparam int unsigned DATA_W   = 32;
  localparam int unsigned ADDR_W   = 8;

  // --------------------------------------------------------------------------
  // Byte offsets
  // --------------------------------------------------------------------------
  localparam logic [7:0] OFF_OWNER_EN      = 8'h00;
  localparam logic [7:0] OFF_OWNER_DIS     = 8'h04;
  localparam logic [7:0] OFF_OWNER_STAT    = 8'h08;
  localparam logic [7:0] OFF_OUT_EN        = 8'h10;
  localparam logic [7:0] OFF_OUT_DIS       = 8'h14;
  localparam logic [7:0] OFF_OUT_STAT      = 8'h18;
  localparam logic [7:0] OFF_SET_OUT       = 8'h30;
  localparam logic [7:0] OFF_CLR_OUT       = 8'h34;
  localparam logic [7:0] OFF_OUT_DATA      = 8'h38;
  localparam logic [7:0] OFF_PIN_LEVEL     = 8'h3c;
  localparam logic [7:0] OFF_IRQ_EN        = 8'h40;
  localparam logic [7:0] OFF_IRQ_DIS       = 8'h44;
  localparam logic [7:0] OFF_IRQ_MASK      = 8'h48;
  localparam logic [7:0] OFF_IRQ_STAT      = 8'h4c;
  localparam logic [7:0] OFF_MD_EN         = 8'h50;
  localparam logic [7:0] OFF_MD_DIS        = 8'h54;
  localparam logic [7:0] OFF_MD_STAT       = 8'h58;
  localparam logic [7:0] OFF_PU_DIS        = 8'h60;
  localparam logic [7:0] OFF_PU_EN         = 8'h64;
  localparam logic [7:0] OFF_PU_STAT       = 8'h68;
  localparam logic [7:0] OFF_SEL_A         = 8'h70;
  localparam logic [7:0] OFF_SEL_B         = 8'h74;
  localparam logic [7:0] OFF_SEL_STAT      = 8'h78;
  localparam logic [7:0] OFF_WMASK_EN      = 8'ha0;
  localparam logic [7:0] OFF_WMASK_DIS     = 8'ha4;
  localparam logic [7:0] OFF_WMASK_STAT    = 8'ha8;

  // --------------------------------------------------------------------------
  // Reset values
  // --------------------------------------------------------------------------
  localparam logic [31:0] RST_ZERO         = 32'h0000_0000;
  localparam logic [31:0] RST_ALL_ONES     = 32'hffff_ffff;

endpackage
`default_nettype wire

/* verilog/pioc_line_ctrl.sv */
// Parallel I/O line controller with Avalon-MM register slave
`timescale 1ns/10ps
`default_nettype none

module pioc_line_ctrl #(
  parameter int unsigned NUM_LINES = 32,
  parameter logic [31:0] LINE_MASK = pioc_pkg::RST_ALL_ONES,
  parameter logic [31:0] MUX_MASK  = pioc_pkg::RST_ALL_ONES,
  parameter logic [31:0] OWNER_RST = pioc_pkg::RST_ALL_ONES
) (
  // Clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  // Gated peripheral clock enable from power manager
  input  wire logic                  pclk_en_i,
  // Avalon-MM slave
  input  wire logic [7:0]            avs_address_i,
  input  wire logic                  avs_read_i,
  input  wire logic                  avs_write_i,
  input  wire logic [31:0]           avs_writedata_i,
  output logic      [31:0]           avs_readdata_o,
  output logic                       avs_waitrequest_o,
  // Pins
  input  wire logic [NUM_LINES-1:0]  pin_i,
  output logic      [NUM_LINES-1:0]  pin_o,
  output logic      [NUM_LINES-1:0]  pin_oe_n_o,
  output logic      [NUM_LINES-1:0]  pullup_en_o,
  // Peripherals A and B
  input  wire logic [NUM_LINES-1:0]  per_a_out_i,
  input  wire logic [NUM_LINES-1:0]  per_a_oe_i,
  input  wire logic [NUM_LINES-1:0]  per_b_out_i,
  input  wire logic [NUM_LINES-1:0]  per_b_oe_i,
  output logic      [NUM_LINES-1:0]  per_in_o,
  // Interrupt
  output logic                       irq_o
);

  // --------------------------------------------------------------------------
  // Line masks
  // --------------------------------------------------------------------------
  // One bit per line
  localparam logic [NUM_LINES-1:0] LMASK = LINE_MASK[NUM_LINES-1:0];
  // Only multiplexed lines accept ownership writes
  localparam logic [NUM_LINES-1:0] MMASK = MUX_MASK[NUM_LINES-1:0] & LMASK;

  logic [NUM_LINES-1:0] owner_r;
  logic [NUM_LINES-1:0] sel_r;
  logic [NUM_LINES-1:0] oe_r;
  logic [NUM_LINES-1:0] odata_r;
  logic [NUM_LINES-1:0] wmask_r;
  logic [NUM_LINES-1:0] md_r;
  logic [NUM_LINES-1:0] pu_r;
  logic [NUM_LINES-1:0] imask_r;
  logic [NUM_LINES-1:0] istat_r;
  logic [NUM_LINES-1:0] level_r;
  logic [NUM_LINES-1:0] sync1_r;
  logic [NUM_LINES-1:0] sync2_r;
  logic [NUM_LINES-1:0] sync3_r;
  logic [NUM_LINES-1:0] read_clr_r;
  logic                 ack_r;
  logic [31:0]          rdata_r;
  logic [31:0]          rdata_nxt;

  // --------------------------------------------------------------------------
  // Bus handshake
  // --------------------------------------------------------------------------
  // One wait cycle per access; the access takes effect on the edge where
  // waitrequest is seen low.
  logic                 acc_wr;
  logic                 acc_rd;
  logic [NUM_LINES-1:0] wd;

  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_r;
  assign acc_wr            = avs_write_i & ack_r;
  assign acc_rd            = avs_read_i & ack_r;
  // Bits of absent lines are dropped on write
  assign wd                = avs_writedata_i[NUM_LINES-1:0] & LMASK;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= (avs_read_i | avs_write_i) & ~ack_r;
    end
  end

  function automatic logic hit(input logic [7:0] off);
    hit = (avs_address_i == off);
  endfunction

  // --------------------------------------------------------------------------
  // Configuration registers
  // --------------------------------------------------------------------------
  // Configuration runs on the free clock, independent of pclk_en_i
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      // Per-line ownership reset, fixed to one where unmultiplexed
      owner_r <= OWNER_RST[NUM_LINES-1:0] | ~MMASK;
    end else if (acc_wr) begin
      if (hit(pioc_pkg::OFF_OWNER_EN)) begin
        owner_r <= owner_r | (wd & MMASK);
      end else if (hit(pioc_pkg::OFF_OWNER_DIS)) begin
        owner_r <= owner_r & ~(wd & MMASK);
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sel_r <= pioc_pkg::RST_ZERO[NUM_LINES-1:0];
    end else if (acc_wr) begin
      // Select writes, taken whatever the owner
      if (hit(pioc_pkg::OFF_SEL_A)) begin
        sel_r <= sel_r & ~wd;
      end else if (hit(pioc_pkg::OFF_SEL_B)) begin
        sel_r <= sel_r | wd;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      oe_r <= pioc_pkg::RST_ZERO[NUM_LINES-1:0];
    end else if (acc_wr) begin
      if (hit(pioc_pkg::OFF_OUT_EN)) begin
        oe_r <= oe_r | wd;
      end else if (hit(pioc_pkg::OFF_OUT_DIS)) begin
        oe_r <= oe_r & ~wd;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      odata_r <= pioc_pkg::RST_ZERO[NUM_LINES-1:0];
    end else if (acc_wr) begin
      // Set and clear of drive data, regardless of owner
      if (hit(pioc_pkg::OFF_SET_OUT)) begin
        odata_r <= odata_r | wd;
      end else if (hit(pioc_pkg::OFF_CLR_OUT)) begin
        odata_r <= odata_r & ~wd;
      end else if (hit(pioc_pkg::OFF_OUT_DATA)) begin
        // Direct write through the write mask
        odata_r <= (odata_r & ~wmask_r) | (wd & wmask_r);
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wmask_r <= pioc_pkg::RST_ZERO[NUM_LINES-1:0];
    end else if (acc_wr) begin
      if (hit(pioc_pkg::OFF_WMASK_EN)) begin
        wmask_r <= wmask_r | wd;
      end else if (hit(pioc_pkg::OFF_WMASK_DIS)) begin
        wmask_r <= wmask_r & ~wd;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      md_r <= pioc_pkg::RST_ZERO[NUM_LINES-1:0];
    end else if (acc_wr) begin
      if (hit(pioc_pkg::OFF_MD_EN)) begin
        md_r <= md_r | wd;
      end else if (hit(pioc_pkg::OFF_MD_DIS)) begin
        md_r <= md_r & ~wd;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pu_r <= pioc_pkg::RST_ZERO[NUM_LINES-1:0];
    end else if (acc_wr) begin
      if (hit(pioc_pkg::OFF_PU_EN)) begin
        pu_r <= pu_r & ~wd;
      end else if (hit(pioc_pkg::OFF_PU_DIS)) begin
        pu_r <= pu_r | wd;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      imask_r <= pioc_pkg::RST_ZERO[NUM_LINES-1:0];
    end else if (acc_wr) begin
      if (hit(pioc_pkg::OFF_IRQ_EN)) begin
        imask_r <= imask_r | wd;
      end else if (hit(pioc_pkg::OFF_IRQ_DIS)) begin
        imask_r <= imask_r & ~wd;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Input sampling
  // --------------------------------------------------------------------------
  // Sampling stalls when the gated clock is off, so the level register keeps
  // the last accepted sample.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sync1_r <= pioc_pkg::RST_ZERO[NUM_LINES-1:0];
      sync2_r <= pioc_pkg::RST_ZERO[NUM_LINES-1:0];
      sync3_r <= pioc_pkg::RST_ZERO[NUM_LINES-1:0];
    end else if (pclk_en_i) begin
      sync1_r <= pin_i;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  logic [NUM_LINES-1:0] agree;
  logic [NUM_LINES-1:0] level_nxt;
  logic [NUM_LINES-1:0] change;

  assign agree     = ~(sync2_r ^ sync3_r);
  assign level_nxt = (level_r & ~agree) | (sync3_r & agree);
  // Change between successive samples, only when clocked
  assign change    = (level_nxt ^ level_r) & {NUM_LINES{pclk_en_i}} & LMASK;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      level_r <= pioc_pkg::RST_ZERO[NUM_LINES-1:0];
    end else if (pclk_en_i) begin
      level_r <= level_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // Interrupt status
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      istat_r <= pioc_pkg::RST_ZERO[NUM_LINES-1:0];
    end else begin
      // Clear only what was returned; a new change wins
      istat_r <= (istat_r & ~(acc_rd ? read_clr_r : '0)) | change;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      // Masked OR, silent while clock stopped
      irq_o <= pclk_en_i & |(istat_r & imask_r);
    end
  end

  // --------------------------------------------------------------------------
  // Read path
  // --------------------------------------------------------------------------
  logic [31:0] owner_w;
  logic [31:0] sel_w;
  logic [31:0] oe_w;
  logic [31:0] odata_w;
  logic [31:0] level_w;
  logic [31:0] imask_w;
  logic [31:0] istat_w;
  logic [31:0] md_w;
  logic [31:0] pu_w;
  logic [31:0] wmask_w;

  assign owner_w = 32'(owner_r & LMASK);
  assign sel_w   = 32'(sel_r);
  assign oe_w    = 32'(oe_r);
  assign odata_w = 32'(odata_r);
  assign level_w = 32'(level_r & LMASK);
  assign imask_w = 32'(imask_r);
  assign istat_w = 32'(istat_r);
  assign md_w    = 32'(md_r);
  assign pu_w    = 32'(pu_r);
  assign wmask_w = 32'(wmask_r);

  always_comb begin
    rdata_nxt = 32'h0000_0000;
    case (avs_address_i)
      pioc_pkg::OFF_OWNER_STAT: rdata_nxt = owner_w;
      pioc_pkg::OFF_SEL_STAT:   rdata_nxt = sel_w;
      pioc_pkg::OFF_OUT_STAT:   rdata_nxt = oe_w;
      pioc_pkg::OFF_OUT_DATA:   rdata_nxt = odata_w;
      pioc_pkg::OFF_PIN_LEVEL:  rdata_nxt = level_w;
      pioc_pkg::OFF_IRQ_MASK:   rdata_nxt = imask_w;
      pioc_pkg::OFF_IRQ_STAT:   rdata_nxt = istat_w;
      pioc_pkg::OFF_MD_STAT:    rdata_nxt = md_w;
      pioc_pkg::OFF_PU_STAT:    rdata_nxt = pu_w;
      pioc_pkg::OFF_WMASK_STAT: rdata_nxt = wmask_w;
      default:                  rdata_nxt = 32'h0000_0000;
    endcase
  end

  // Data captured in the wait cycle stands on the accepting edge.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_r <= 32'h0000_0000;
    end else if (avs_read_i & ~ack_r) begin
      rdata_r <= rdata_nxt;
    end
  end

  // Remember what the read returns, so only those bits clear
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      read_clr_r <= pioc_pkg::RST_ZERO[NUM_LINES-1:0];
    end else if (avs_read_i & ~ack_r) begin
      read_clr_r <= hit(pioc_pkg::OFF_IRQ_STAT) ? istat_r : '0;
    end
  end

  assign avs_readdata_o = rdata_r;

  // --------------------------------------------------------------------------
  // Pin drive
  // --------------------------------------------------------------------------
  logic [NUM_LINES-1:0] per_oe;
  logic [NUM_LINES-1:0] per_d;
  logic [NUM_LINES-1:0] drv_oe;
  logic [NUM_LINES-1:0] drv_d;
  logic [NUM_LINES-1:0] eff_oe;

  // Per-line drive mux: ownership first, then peripheral A or B
  for (genvar gi = 0; gi < NUM_LINES; gi++) begin : g_line
    // A/B choice steers the drive path only
    assign per_oe[gi] = sel_r[gi] ? per_b_oe_i[gi]  : per_a_oe_i[gi];
    assign per_d[gi]  = sel_r[gi] ? per_b_out_i[gi] : per_a_out_i[gi];
    // Peripheral drives when not owned, else output status
    assign drv_oe[gi] = owner_r[gi] ? oe_r[gi]    : per_oe[gi];
    assign drv_d[gi]  = owner_r[gi] ? odata_r[gi] : per_d[gi];
    // Open drain releases the pin for a high level; absent lines never drive
    assign eff_oe[gi] = drv_oe[gi] & LMASK[gi] & ~(md_r[gi] & drv_d[gi]);
  end

  // Registered pin outputs keep decode glitches off the pads
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pin_o <= pioc_pkg::RST_ZERO[NUM_LINES-1:0];
    end else begin
      pin_o <= drv_d & ~md_r;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pin_oe_n_o <= pioc_pkg::RST_ALL_ONES[NUM_LINES-1:0];
    end else begin
      pin_oe_n_o <= ~eff_oe;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      // Pull-ups of present lines on from reset
      pullup_en_o <= LMASK;
    end else begin
      pullup_en_o <= ~pu_r & LMASK;
    end
  end

  // Both peripherals see the raw pin
  assign per_in_o = pin_i;

endmodule

`default_nettype wire

/* verification/pioc_line_ctrl_checker.sv */
// Port-level assertions for the parallel I/O line controller
`timescale 1ns/10ps
`default_nettype none

module pioc_line_ctrl_checker #(
  parameter int unsigned NUM_LINES = 32,
  parameter logic [31:0] LINE_MASK = 32'hffff_ffff
) (
  // Clock, reset and gated clock enable
  input wire logic                 clk_i,
  input wire logic                 rst_i,
  input wire logic                 pclk_en_i,
  // Register bus
  input wire logic [7:0]           avs_address_i,
  input wire logic                 avs_read_i,
  input wire logic                 avs_write_i,
  input wire logic [31:0]          avs_readdata_o,
  input wire logic                 avs_waitrequest_o,
  // Pins, peripheral input and interrupt
  input wire logic [NUM_LINES-1:0] pin_i,
  input wire logic [NUM_LINES-1:0] pin_oe_n_o,
  input wire logic [NUM_LINES-1:0] pullup_en_o,
  input wire logic [NUM_LINES-1:0] per_in_o,
  input wire logic                 irq_o
);
  default clocking dcb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Quiet time with the gated clock running; a pin change takes several edges to reach the flags
  logic [NUM_LINES-1:0] pin_q_r;
  logic [3:0]           quiet_r;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pin_q_r <= '0;
      quiet_r <= 4'h0;
    end else begin
      // Absent lines float freely and must not hold the count down
      pin_q_r <= pin_i & LINE_MASK[NUM_LINES-1:0];
      if ((pin_i & LINE_MASK[NUM_LINES-1:0]) != pin_q_r || !pclk_en_i) begin
        quiet_r <= 4'h0;
      end else if (quiet_r != 4'hf) begin
        quiet_r <= quiet_r + 4'h1;
      end
    end
  end

  a_wait_one_cycle: assert property (
    $rose(avs_read_i || avs_write_i) |-> avs_waitrequest_o ##1 !avs_waitrequest_o) else $error("bad wait");
  a_inputs_shared: assert property (
    per_in_o == pin_i) else $error("peripheral input differs from pin");
  a_absent_idle: assert property (
    (pin_oe_n_o | LINE_MASK[NUM_LINES-1:0]) == {NUM_LINES{1'b1}}) else $error("absent line driven");
  a_absent_read_zero: assert property (
    avs_read_i && !avs_waitrequest_o |-> (avs_readdata_o & ~LINE_MASK) == 32'h0) else $error("absent bit read");
  a_reset_pins: assert property (
    $fell(rst_i) |-> pin_oe_n_o == {NUM_LINES{1'b1}} && pullup_en_o == LINE_MASK[NUM_LINES-1:0])
    else $error("pin defaults wrong");
  a_irq_gated_off: assert property (
    !pclk_en_i [*2] |-> !irq_o) else $error("irq without clock");
  a_irq_read_clear: assert property (
    avs_read_i && !avs_waitrequest_o && avs_address_i == pioc_pkg::OFF_IRQ_STAT && quiet_r > 4'h8
    |-> ##2 !irq_o) else $error("irq kept after status read");
  a_irq_has_cause: assert property (
    $rose(irq_o) |-> quiet_r < 4'hc || $past(avs_write_i, 2) || $past(avs_write_i, 3))
    else $error("irq without change");

  c_irq_raised: cover property ($rose(irq_o));
  c_read_done: cover property (avs_read_i && !avs_waitrequest_o);
  c_write_no_clock: cover property (avs_write_i && !avs_waitrequest_o && !pclk_en_i);
endmodule

bind pioc_line_ctrl pioc_line_ctrl_checker #(.NUM_LINES(NUM_LINES), .LINE_MASK(LINE_MASK)) u_checker (
  .clk_i(clk_i), .rst_i(rst_i), .pclk_en_i(pclk_en_i), .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o), .pin_i(pin_i), .pin_oe_n_o(pin_oe_n_o),
  .pullup_en_o(pullup_en_o), .per_in_o(per_in_o), .irq_o(irq_o)
);

`default_nettype wire

/* verification/pioc_pin_model.sv */
// Board-side model of the pins: design drive, external source, pull-up and floating lines
`timescale 1ns/10ps
`default_nettype none

module pioc_pin_model #(
  parameter int unsigned NUM_LINES = 32
) (
  // Clock
  input  wire logic                 clk_i,
  // Design drive
  input  wire logic [NUM_LINES-1:0] drv_d_i,
  input  wire logic [NUM_LINES-1:0] drv_oe_n_i,
  input  wire logic [NUM_LINES-1:0] pullup_en_i,
  // External source
  input  wire logic [NUM_LINES-1:0] ext_en_i,
  input  wire logic [NUM_LINES-1:0] ext_i,
  // Resolved level
  output logic      [NUM_LINES-1:0] pin_lvl_o
);
  logic [NUM_LINES-1:0] last_r;

  always_ff @(posedge clk_i) begin
    last_r <= pin_lvl_o;
  end

  always_comb begin
    for (int i = 0; i < NUM_LINES; i++) begin
      if (!drv_oe_n_i[i]) begin
        pin_lvl_o[i] = drv_d_i[i];
      end else if (ext_en_i[i]) begin
        pin_lvl_o[i] = ext_i[i];
      end else if (pullup_en_i[i]) begin
        pin_lvl_o[i] = 1'b1;
      end else begin
        // Undriven line: any level, so it keeps flipping from a known start
        pin_lvl_o[i] = (last_r[i] !== 1'b1);
      end
    end
  end
endmodule

`default_nettype wire

/* verification/pioc_line_ctrl_tb_top.sv */
// Self-checking testbench of the parallel I/O line controller
`timescale 1ns/10ps
`default_nettype none

module pioc_line_ctrl_tb_top;
  localparam logic [31:0] LM   = 32'h7fff_ffff;
  localparam logic [31:0] MM   = 32'hbfff_ffff;
  localparam logic [31:0] ORST = 32'hffff_fffe;
  logic        clk_i, rst_i, pclk_en_i, avs_read_i, avs_write_i, avs_waitrequest_o, irq_o;
  logic [7:0]  avs_address_i;
  logic [31:0] avs_writedata_i, avs_readdata_o, pin_o, pin_oe_n_o, pullup_en_o, per_in_o;
  logic [31:0] per_a_out_i, per_a_oe_i, per_b_out_i, per_b_oe_i, ext_en, ext_lvl, d, q, e;
  logic [31:0] sh [7];
  logic [7:0]  ba [7] = '{pioc_pkg::OFF_OWNER_EN, pioc_pkg::OFF_OUT_EN, pioc_pkg::OFF_SET_OUT,
                          pioc_pkg::OFF_MD_EN, pioc_pkg::OFF_PU_DIS, pioc_pkg::OFF_SEL_A, pioc_pkg::OFF_WMASK_EN};
  wire  [31:0] pin_i;
  int unsigned err_total, samples_checked, k, b, seed_v;

  pioc_line_ctrl #(.NUM_LINES(32), .LINE_MASK(LM), .MUX_MASK(MM), .OWNER_RST(ORST)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .pclk_en_i(pclk_en_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o), .pin_i(pin_i),
    .pin_o(pin_o), .pin_oe_n_o(pin_oe_n_o), .pullup_en_o(pullup_en_o), .per_a_out_i(per_a_out_i),
    .per_a_oe_i(per_a_oe_i), .per_b_out_i(per_b_out_i), .per_b_oe_i(per_b_oe_i), .per_in_o(per_in_o),
    .irq_o(irq_o));

  pioc_pin_model #(.NUM_LINES(32)) u_pins (.clk_i(clk_i), .drv_d_i(pin_o), .drv_oe_n_i(pin_oe_n_o),
    .pullup_en_i(pullup_en_o), .ext_en_i(ext_en), .ext_i(ext_lvl), .pin_lvl_o(pin_i));

  function automatic logic [31:0] upd(input logic [31:0] cur, s, c);
    return (cur | s) & ~c & LM;
  endfunction
  // Lines without a peripheral always read as owned
  function automatic logic [31:0] own_exp(input logic [31:0] v);
    return (v | ~MM) & LM;
  endfunction
  function automatic logic [63:0] pins_exp();
    logic [31:0] po, pd, oe, dd;
    po = (sh[5] & per_b_oe_i) | (~sh[5] & per_a_oe_i);
    pd = (sh[5] & per_b_out_i) | (~sh[5] & per_a_out_i);
    oe = (sh[0] & sh[1]) | (~sh[0] & po);
    dd = (sh[0] & sh[2]) | (~sh[0] & pd);
    return {~(oe & LM & ~(sh[3] & dd)), dd & ~sh[3] & LM};
  endfunction

  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Hold the request until waitrequest is sampled low, then release
  task automatic acc(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    int n;
    @(posedge clk_i);
    avs_address_i <= a;
    avs_writedata_i <= wd;
    avs_write_i <= wr;
    avs_read_i <= !wr;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 50);
    rd = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
    if (avs_waitrequest_o !== 1'b0) begin
      err_total++;
      end_sim();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] r;
    acc(1'b1, a, wd, r);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    acc(1'b0, a, 32'h0, r);
    chk(r, exp);
  endtask
  task automatic chk_regs();
    for (int i = 0; i < 7; i++) begin
      rdc(ba[i] + 8'h08, sh[i]);
    end
  endtask
  task automatic chk_pins();
    logic [63:0] x;
    repeat (2) @(posedge clk_i);
    x = pins_exp();
    chk(pin_oe_n_o, x[63:32]);
    chk(pin_o & LM, x[31:0]);
    chk(pullup_en_o, ~sh[4] & LM);
    chk(per_in_o, pin_i);
  endtask
  task automatic do_reset();
    rst_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    sh = '{default: 32'h0};
    sh[0] = own_exp(ORST);
  endtask

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  initial begin
    repeat (90000) @(posedge clk_i);
    err_total++;
    end_sim();
  end

  initial begin
    {rst_i, pclk_en_i, avs_read_i, avs_write_i, avs_address_i, avs_writedata_i} = '0;
    {per_a_out_i, per_a_oe_i, per_b_out_i, per_b_oe_i, ext_en, ext_lvl} = '0;
    seed_v = $urandom(5833);
    do_reset();
    chk_regs();
    // hand-over comes from select and owner writes in the random mix
    for (int i = 0; i < 60; i++) begin
      k = (i == 0) ? 7 : $urandom_range(7);
      d = $urandom();
      b = $urandom_range(1);
      {per_a_out_i, per_a_oe_i} <= {$urandom(), $urandom()};
      {per_b_out_i, per_b_oe_i} <= {$urandom(), $urandom()};
      if (k == 7) begin
        wr(pioc_pkg::OFF_OUT_DATA, d);
        sh[2] = ((sh[2] & ~sh[6]) | (d & sh[6])) & LM;
      end else begin
        wr(((k == 5) ^ (b == 1)) ? ba[k] + 8'h04 : ba[k], d);
        sh[k] = (b == 1) ? upd(sh[k], 32'h0, d) : upd(sh[k], d, 32'h0);
        sh[0] = own_exp(sh[0]);
      end
      chk_pins();
      chk_regs();
    end
    wr(8'h0c, 32'hffff_ffff);
    wr(pioc_pkg::OFF_OWNER_STAT, 32'h0);
    rdc(8'h0c, 32'h0);
    chk_regs();
    // gated clock on before pin reads
    pclk_en_i <= 1'b1;
    e = $urandom();
    ext_lvl <= e;
    ext_en <= 32'hffff_ffff;
    wr(pioc_pkg::OFF_OWNER_EN, 32'hffff_ffff);
    wr(pioc_pkg::OFF_OUT_DIS, 32'hffff_ffff);
    wr(pioc_pkg::OFF_PU_DIS, 32'hffff_ffff);
    wr(pioc_pkg::OFF_IRQ_EN, 32'h0000_0001);
    repeat (10) @(posedge clk_i);
    wr(pioc_pkg::OFF_IRQ_STAT + 8'h00, 32'h0);
    rdc(pioc_pkg::OFF_PIN_LEVEL, e & LM);
    acc(1'b0, pioc_pkg::OFF_IRQ_STAT, 32'h0, q);
    e = e ^ 32'h0000_0101;
    ext_lvl <= e;
    repeat (10) @(posedge clk_i);
    chk({31'h0, irq_o}, 32'h1);
    rdc(pioc_pkg::OFF_IRQ_STAT, 32'h0000_0101);
    rdc(pioc_pkg::OFF_IRQ_STAT, 32'h0);
    repeat (3) @(posedge clk_i);
    chk({31'h0, irq_o}, 32'h0);
    pclk_en_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    ext_lvl <= e ^ 32'h0000_0001;
    repeat (10) @(posedge clk_i);
    chk({31'h0, irq_o}, 32'h0);
    rdc(pioc_pkg::OFF_PIN_LEVEL, e & LM);
    pclk_en_i <= 1'b1;
    repeat (10) @(posedge clk_i);
    rdc(pioc_pkg::OFF_PIN_LEVEL, (e ^ 32'h0000_0001) & LM);
    ext_en <= 32'h0;
    do_reset();
    chk_regs();
    chk_pins();
    end_sim();
  end
endmodule

`default_nettype wire
